/* verilog/aclkg_pkg.sv */
// Constants shared by the audio clock generator and cleaner
package aclkg_pkg;
  localparam logic [7:0] ACLKG_OFS_RATIO_CTRL = 8'h30;
  localparam logic [7:0] ACLKG_OFS_TS_LOW     = 8'h31;
  localparam logic [7:0] ACLKG_OFS_TS_MID     = 8'h32;
  localparam logic [7:0] ACLKG_OFS_TS_HIGH    = 8'h33;
  localparam logic [7:0] ACLKG_OFS_DIV_LOW    = 8'h34;
  localparam logic [7:0] ACLKG_OFS_DIV_MID    = 8'h35;
  localparam logic [7:0] ACLKG_OFS_DIV_HIGH   = 8'h36;
  localparam logic [7:0] ACLKG_OFS_FIFO_LVL   = 8'h37;

  localparam logic [7:0] ACLKG_RST_BYTE = 8'h00;

  localparam int ACLKG_POS_FRAME_RATIO = 7;
  localparam int ACLKG_POS_MCLK_LSB    = 5;
  localparam int ACLKG_POS_REF_LSB     = 3;
  localparam int ACLKG_POS_CLEAN_LSB   = 1;
  localparam int ACLKG_POS_DRIVE       = 0;
  localparam int ACLKG_POS_COEFF_LSB   = 4;
  localparam int ACLKG_POS_IN_FILL_LSB = 3;
  localparam int ACLKG_POS_OUT_FILL_LSB = 0;

  // Master-clock periods per bit-clock period, by code
  localparam logic [3:0] ACLKG_MCLK_RATIO_00 = 4'h4;
  localparam logic [3:0] ACLKG_MCLK_RATIO_01 = 4'h2;
  localparam logic [3:0] ACLKG_MCLK_RATIO_10 = 4'h1;
  localparam logic [3:0] ACLKG_MCLK_RATIO_11 = 4'h8;

  // Last bit-clock count per half frame (32 or 16 periods)
  localparam logic [4:0] ACLKG_HALF_FRAME_64 = 5'h1f;
  localparam logic [4:0] ACLKG_HALF_FRAME_32 = 5'h0f;

  // Reference divider terminal counts for /8, /4, /2
  localparam logic [2:0] ACLKG_REF_LAST_8 = 3'h7;
  localparam logic [2:0] ACLKG_REF_LAST_4 = 3'h3;
  localparam logic [2:0] ACLKG_REF_LAST_2 = 3'h1;
  localparam logic [1:0] ACLKG_REF_OSC    = 2'h3;

  localparam logic [2:0] ACLKG_FILL_MAX = 3'h7;
endpackage : aclkg_pkg

/* verilog/aclkg_sync3.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module aclkg_sync3 (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic async_in,
  output var  logic sync_out
);
  typedef struct packed {
    logic [2:0] ff;
    logic       agreed;
  } aclkg_sync_type;

  aclkg_sync_type q;
  aclkg_sync_type s;

  always_comb begin
    s = q;
    s.ff[0] = async_in;
    s.ff[1] = q.ff[0];
    s.ff[2] = q.ff[1];
    // Only stages two and three are compared; stage one may be metastable
    if (q.ff[1] == q.ff[2]) begin
      s.agreed = q.ff[2];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= s;
    end
  end

  assign sync_out = q.agreed;
endmodule : aclkg_sync3
`default_nettype wire

/* verilog/aclkg_audio_clock_gen_cleaner.sv */
// Audio clock generator, regenerator and digital clock cleaner
// How it works
// - Frame ratio bit picks 64 or 32
// - Two bits pick master/bit ratio 4,2,1,8
// - Reference is VCO /8,/4,/2 or oscillator
// - Nonzero cleaning mode smooths clock, ratio 1/2/4
// - Drive bit makes pins outputs, enables generation
// - 24-bit time-stamp, nonzero enables regeneration
// - 20-bit divider from two bytes plus nibble
// - Loop filter feedback divided by two^coefficient
// - Report input and output fill levels
`timescale 1ns/1ps
`default_nettype none
module aclkg_audio_clock_gen_cleaner (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  output var  logic [7:0] reg_rdata,
  input  wire logic       link_pll_vco_clock,
  input  wire logic       always_on_oscillator,
  input  wire logic       bit_clock_pin_in,
  output var  logic       bit_clock_pin_out,
  output var  logic       bit_clock_pin_oe,
  input  wire logic       frame_sync_pin_in,
  output var  logic       frame_sync_pin_out,
  output var  logic       frame_sync_pin_oe,
  output var  logic       master_clock_out,
  output var  logic       cleaned_clock_out
);
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [23:0] cts;
    logic [19:0] n;
    logic [3:0]  coeff;
    logic [7:0]  rdata;
    logic        vco_d;
    logic        osc_d;
    logic        bclk_d;
    logic [2:0]  ref_div;
    logic [24:0] acc;
    logic [15:0] per_cnt;
    logic [15:0] est;
    logic [15:0] gap_cnt;
    logic [2:0]  grp_cnt;
    logic [2:0]  in_fill;
    logic [2:0]  out_fill;
    logic [3:0]  mdiv;
    logic [4:0]  bdiv;
    logic        mclk;
    logic        bclk;
    logic        fs;
    logic        drive;
    logic        clean_clk;
  } aclkg_state_type;

  aclkg_state_type q;
  aclkg_state_type s;

  logic [3:0] pin_raw;
  logic [3:0] pin_sync;

  assign pin_raw = {frame_sync_pin_in, bit_clock_pin_in, always_on_oscillator, link_pll_vco_clock};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      aclkg_sync3 u_sync (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .async_in (pin_raw[gi]),
        .sync_out (pin_sync[gi])
      );
    end
  endgenerate

  logic               vco_rise;
  logic               osc_rise;
  logic               bclk_rise;
  logic               ref_tick;
  logic               regen_tick;
  logic               src_tick;
  logic               emit;
  logic               gen_tick;
  logic               in_dec;
  logic [2:0]         ref_last;
  logic [24:0]        sum;
  logic [1:0]         clean_mode;
  logic [15:0]        interval;
  logic [2:0]         grp_last;
  logic signed [16:0] diff;
  logic signed [16:0] diff_sh;
  logic [3:0]         mclk_ratio;
  logic [4:0]         half_frame;

  always_comb begin
    s = q;
    vco_rise   = pin_sync[0] & ~q.vco_d;
    osc_rise   = pin_sync[1] & ~q.osc_d;
    bclk_rise  = pin_sync[2] & ~q.bclk_d;
    s.vco_d    = pin_sync[0];
    s.osc_d    = pin_sync[1];
    s.bclk_d   = pin_sync[2];
    ref_tick   = 1'b0;
    regen_tick = 1'b0;
    emit       = 1'b0;
    gen_tick   = 1'b0;
    in_dec     = 1'b0;
    interval   = 16'h0000;
    grp_last   = 3'h0;
    diff       = 17'sh00000;
    diff_sh    = 17'sh00000;

    // Register writes; the fill-level register has no write path
    if (reg_wr) begin
      case (reg_addr)
        aclkg_pkg::ACLKG_OFS_RATIO_CTRL: s.ctrl = reg_wdata;
        aclkg_pkg::ACLKG_OFS_TS_LOW:     s.cts[7:0] = reg_wdata;
        aclkg_pkg::ACLKG_OFS_TS_MID:     s.cts[15:8] = reg_wdata;
        aclkg_pkg::ACLKG_OFS_TS_HIGH:    s.cts[23:16] = reg_wdata;
        aclkg_pkg::ACLKG_OFS_DIV_LOW:    s.n[7:0] = reg_wdata;
        aclkg_pkg::ACLKG_OFS_DIV_MID:    s.n[15:8] = reg_wdata;
        aclkg_pkg::ACLKG_OFS_DIV_HIGH: begin
          s.n[19:16] = reg_wdata[3:0];
          s.coeff    = reg_wdata[aclkg_pkg::ACLKG_POS_COEFF_LSB +: 4];
        end
        default: ;
      endcase
    end

    // Registered read data, zero for unmapped offsets
    if (reg_rd) begin
      case (reg_addr)
        aclkg_pkg::ACLKG_OFS_RATIO_CTRL: s.rdata = q.ctrl;
        aclkg_pkg::ACLKG_OFS_TS_LOW:     s.rdata = q.cts[7:0];
        aclkg_pkg::ACLKG_OFS_TS_MID:     s.rdata = q.cts[15:8];
        aclkg_pkg::ACLKG_OFS_TS_HIGH:    s.rdata = q.cts[23:16];
        aclkg_pkg::ACLKG_OFS_DIV_LOW:    s.rdata = q.n[7:0];
        aclkg_pkg::ACLKG_OFS_DIV_MID:    s.rdata = q.n[15:8];
        aclkg_pkg::ACLKG_OFS_DIV_HIGH:   s.rdata = {q.coeff, q.n[19:16]};
        aclkg_pkg::ACLKG_OFS_FIFO_LVL:   s.rdata = {2'h0, q.in_fill, q.out_fill};
        default:                         s.rdata = aclkg_pkg::ACLKG_RST_BYTE;
      endcase
    end

    // Reference selection
    case (q.ctrl[aclkg_pkg::ACLKG_POS_REF_LSB +: 2])
      2'h0:    ref_last = aclkg_pkg::ACLKG_REF_LAST_8;
      2'h1:    ref_last = aclkg_pkg::ACLKG_REF_LAST_4;
      2'h2:    ref_last = aclkg_pkg::ACLKG_REF_LAST_2;
      default: ref_last = aclkg_pkg::ACLKG_REF_LAST_2;
    endcase
    if (q.ctrl[aclkg_pkg::ACLKG_POS_REF_LSB +: 2] == aclkg_pkg::ACLKG_REF_OSC) begin
      ref_tick  = osc_rise;
      s.ref_div = 3'h0;
    end else if (vco_rise) begin
      if (q.ref_div >= ref_last) begin
        ref_tick  = 1'b1;
        s.ref_div = 3'h0;
      end else begin
        s.ref_div = q.ref_div + 3'h1;
      end
    end

    // Time-stamp/divider regeneration; one output tick per cycle, so keep divider below time-stamp
    sum = q.acc + (ref_tick ? {5'h00, q.n} : 25'h0000000);
    if ((q.cts != 24'h000000) && (sum >= {1'b0, q.cts})) begin
      regen_tick = 1'b1;
      sum        = sum - {1'b0, q.cts};
    end
    s.acc = (q.cts != 24'h000000) ? sum : 25'h0000000;

    if (q.ctrl[aclkg_pkg::ACLKG_POS_DRIVE]) begin
      src_tick = (q.cts != 24'h000000) ? regen_tick : ref_tick;
    end else begin
      src_tick = bclk_rise;
    end

    // Cleaner: period estimate filtered, ratio ticks paced per input period
    clean_mode = q.ctrl[aclkg_pkg::ACLKG_POS_CLEAN_LSB +: 2];
    if (clean_mode == 2'h0) begin
      gen_tick   = src_tick;
      s.in_fill  = 3'h0;
      s.out_fill = 3'h0;
      s.per_cnt  = 16'h0000;
      s.gap_cnt  = 16'h0000;
      s.grp_cnt  = 3'h0;
    end else begin
      s.per_cnt = (q.per_cnt == 16'hffff) ? q.per_cnt : q.per_cnt + 16'h0001;
      if (src_tick) begin
        diff      = $signed({1'b0, q.per_cnt}) - $signed({1'b0, q.est});
        diff_sh   = diff >>> q.coeff;
        s.est     = q.est + diff_sh[15:0];
        s.per_cnt = 16'h0000;
      end
      case (clean_mode)
        2'h1:    begin interval = q.est;      grp_last = 3'h0; end
        2'h2:    begin interval = q.est >> 1; grp_last = 3'h1; end
        default: begin interval = q.est >> 2; grp_last = 3'h3; end
      endcase
      s.gap_cnt = (q.gap_cnt == 16'hffff) ? q.gap_cnt : q.gap_cnt + 16'h0001;
      if ((q.in_fill != 3'h0) && (q.gap_cnt >= interval)) begin
        emit      = 1'b1;
        s.gap_cnt = 16'h0000;
        if (q.grp_cnt >= grp_last) begin
          s.grp_cnt = 3'h0;
          in_dec    = 1'b1;
        end else begin
          s.grp_cnt = q.grp_cnt + 3'h1;
        end
      end
      // Saturating fill counts; arrival and departure together leave level unchanged
      if (src_tick && !in_dec && (q.in_fill != aclkg_pkg::ACLKG_FILL_MAX)) begin
        s.in_fill = q.in_fill + 3'h1;
      end else if (!src_tick && in_dec) begin
        s.in_fill = q.in_fill - 3'h1;
      end
      gen_tick = (q.out_fill != 3'h0);
      if (emit && !gen_tick && (q.out_fill != aclkg_pkg::ACLKG_FILL_MAX)) begin
        s.out_fill = q.out_fill + 3'h1;
      end else if (!emit && gen_tick) begin
        s.out_fill = q.out_fill - 3'h1;
      end
    end

    if (gen_tick) begin
      s.clean_clk = ~q.clean_clk;
    end

    // Master, bit and frame clock generation
    case (q.ctrl[aclkg_pkg::ACLKG_POS_MCLK_LSB +: 2])
      2'h0:    mclk_ratio = aclkg_pkg::ACLKG_MCLK_RATIO_00;
      2'h1:    mclk_ratio = aclkg_pkg::ACLKG_MCLK_RATIO_01;
      2'h2:    mclk_ratio = aclkg_pkg::ACLKG_MCLK_RATIO_10;
      default: mclk_ratio = aclkg_pkg::ACLKG_MCLK_RATIO_11;
    endcase
    half_frame = q.ctrl[aclkg_pkg::ACLKG_POS_FRAME_RATIO] ?
                 aclkg_pkg::ACLKG_HALF_FRAME_32 : aclkg_pkg::ACLKG_HALF_FRAME_64;
    s.drive = q.ctrl[aclkg_pkg::ACLKG_POS_DRIVE];
    if (!q.ctrl[aclkg_pkg::ACLKG_POS_DRIVE]) begin
      s.mclk = 1'b0;
      s.bclk = 1'b0;
      s.fs   = 1'b0;
      s.mdiv = 4'h0;
      s.bdiv = 5'h00;
    end else if (gen_tick) begin
      s.mclk = ~q.mclk;
      // Bit clock toggles every ratio master ticks, so its period is ratio master periods
      if (q.mdiv >= mclk_ratio - 4'h1) begin
        s.mdiv = 4'h0;
        s.bclk = ~q.bclk;
        if (q.bclk) begin
          if (q.bdiv >= half_frame) begin
            s.bdiv = 5'h00;
            s.fs   = ~q.fs;
          end else begin
            s.bdiv = q.bdiv + 5'h01;
          end
        end
      end else begin
        s.mdiv = q.mdiv + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= s;
    end
  end

  assign reg_rdata          = q.rdata;
  assign bit_clock_pin_out  = q.bclk;
  assign bit_clock_pin_oe   = q.drive;
  assign frame_sync_pin_out = q.fs;
  assign frame_sync_pin_oe  = q.drive;
  assign master_clock_out   = q.mclk;
  assign cleaned_clock_out  = q.clean_clk;
endmodule : aclkg_audio_clock_gen_cleaner
`default_nettype wire

/* dv/aclkg_asserts.sv */
// Checker for the audio clock block ports
`timescale 1ns/1ps
`default_nettype none
module aclkg_asserts (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       bit_clock_pin_out,
  input wire logic       bit_clock_pin_oe,
  input wire logic       frame_sync_pin_out,
  input wire logic       frame_sync_pin_oe,
  input wire logic       master_clock_out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_pins_paired: assert property (
    bit_clock_pin_oe == frame_sync_pin_oe) else $error("pin enables differ");
  a_drive_oe: assert property (
    reg_wr && reg_addr == 8'h30 |-> ##2 bit_clock_pin_oe == $past(reg_wdata[0], 2))
    else $error("enable not from drive bit");
  a_idle_quiet: assert property (
    !bit_clock_pin_oe [*3] |-> !master_clock_out && !bit_clock_pin_out && !frame_sync_pin_out)
    else $error("clock out while receiving");
  a_ro_top_zero: assert property (
    reg_rd && reg_addr == 8'h37 |=> reg_rdata[7:6] == 2'h0) else $error("reserved bits set");
  a_unmapped_zero: assert property (
    reg_rd && !(reg_addr inside {[8'h30:8'h37]}) |=> reg_rdata == 8'h00) else $error("unmapped read");
  a_rw_readback: assert property (
    reg_wr && reg_addr inside {[8'h30:8'h36]} ##1 reg_rd && reg_addr == $past(reg_addr)
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("readback differs");
  a_rdata_hold: assert property (
    !reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
  a_bit_on_tick: assert property (
    bit_clock_pin_oe && !$past(reg_wr) && $changed(bit_clock_pin_out) |-> $changed(master_clock_out))
    else $error("bit clock off tick");
  a_frame_on_fall: assert property (
    bit_clock_pin_oe && !$past(reg_wr) && $changed(frame_sync_pin_out) |-> $fell(bit_clock_pin_out))
    else $error("frame sync off fall");
endmodule : aclkg_asserts
bind aclkg_audio_clock_gen_cleaner aclkg_asserts aclkg_asserts_i (.clk_sys(clk_sys), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .bit_clock_pin_out(bit_clock_pin_out), .bit_clock_pin_oe(bit_clock_pin_oe),
  .frame_sync_pin_out(frame_sync_pin_out), .frame_sync_pin_oe(frame_sync_pin_oe),
  .master_clock_out(master_clock_out));
`default_nettype wire

/* dv/aclkg_partner.sv */
// Serial audio source on the bit clock and frame sync pins
`timescale 1ns/1ps
`default_nettype none
module aclkg_partner #(
  parameter int HALF = 8
) (
  input  wire logic clk_sys,
  input  wire logic run,
  output var  logic bclk,
  output var  logic fsync
);
  int         cnt;
  logic [4:0] nbit;
  // Bit clock stands still while the source is stopped
  always @(negedge clk_sys) begin
    if (!run) begin
      cnt   <= 0;
      nbit  <= 5'h00;
      bclk  <= 1'b0;
      fsync <= 1'b0;
    end else begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) begin
        bclk <= !bclk;
        if (bclk) begin
          nbit <= nbit + 5'h01;
          if (nbit == 5'h1f) fsync <= !fsync;
        end
      end
    end
  end
endmodule : aclkg_partner
`default_nettype wire

/* dv/tb_top.sv */
// Register and clock pin tests for the audio clock block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       clk_sys, rst_n, reg_wr, reg_rd, run = 1'b0;
  logic       vco = 1'b0, osc = 1'b0, bclk_o, bclk_oe, fs_o, fs_oe, mclk, cln, p_bclk, p_fs;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  int         err_count = 0, n_tests = 0;
  logic [15:0] rt [4] = '{16'h4, 16'h2, 16'h1, 16'h8};
  aclkg_audio_clock_gen_cleaner aclkg_audio_clock_gen_cleaner_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .link_pll_vco_clock(vco), .always_on_oscillator(osc), .bit_clock_pin_in(bclk_oe ? bclk_o : p_bclk),
    .bit_clock_pin_out(bclk_o), .bit_clock_pin_oe(bclk_oe), .frame_sync_pin_in(fs_oe ? fs_o : p_fs),
    .frame_sync_pin_out(fs_o), .frame_sync_pin_oe(fs_oe), .master_clock_out(mclk), .cleaned_clock_out(cln));
  aclkg_partner aclkg_partner_i (.clk_sys(clk_sys), .run(run), .bclk(p_bclk), .fsync(p_fs));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always begin
    repeat (5) @(negedge clk_sys);
    vco = ~vco;
  end
  always begin
    repeat (4) @(negedge clk_sys);
    osc = ~osc;
  end
  task automatic summarize();
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %0h got %0h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    @(negedge clk_sys);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    chk("reg", {8'h00, e}, {8'h00, reg_rdata & m});
  endtask : rc
  // Write then read the same offset on the very next edge
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    chk("wr_rd", {8'h00, d}, {8'h00, reg_rdata});
  endtask : wr_rd
  // Counts b rises (4: cycles) in one a period; first period skipped after a change
  task automatic cnt(input int a, input int b, output int n);
    logic [3:0] c, p;
    int         i, k;
    p = '1;
    n = 0;
    k = 0;
    for (i = 0; i < 20000 && k < 3; i++) begin
      @(negedge clk_sys);
      c = {cln, fs_o, bclk_o, mclk};
      if (k == 2 && (b == 4 || (c[b] && !p[b]))) n++;
      if (c[a] && !p[a]) k++;
      p = c;
    end
    if (k < 3) n = -1;
  endtask : cnt
  initial begin
    int i, n;
    rst_n = 1'b0;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    for (i = 0; i < 8; i++) rc(8'h30 + 8'(i), 8'h00, 8'hff);
    for (i = 0; i < 6; i++) wr(8'h31 + 8'(i), 8'h5a ^ 8'(i));
    wr(8'h30, 8'hfe);
    wr(8'h37, 8'hff);
    wr(8'h38, 8'hff);
    for (i = 0; i < 6; i++) rc(8'h31 + 8'(i), 8'h5a ^ 8'(i), 8'hff);
    rc(8'h30, 8'hfe, 8'hff);
    rc(8'h37, 8'h00, 8'hff);
    rc(8'h38, 8'h00, 8'hff);
    wr_rd(8'h32, 8'ha5);
    wr_rd(8'h36, 8'h3c);
    for (i = 0; i < 6; i++) wr(8'h31 + 8'(i), 8'h00);
    for (i = 0; i < 4; i++) begin
      wr(8'h30, {1'b1, 2'(i), 5'h19});
      cnt(1, 0, n);
      chk("mclk_per_bit", rt[i], 16'(n));
    end
    for (i = 0; i < 2; i++) begin
      wr(8'h30, {1'(i), 2'h2, 5'h19});
      cnt(2, 1, n);
      chk("bits_per_frame", i ? 16'h20 : 16'h40, 16'(n));
    end
    for (i = 0; i < 4; i++) begin
      wr(8'h30, {3'h4, 2'(i), 3'h1});
      cnt(0, 4, n);
      chk("ref_period", (i == 3) ? 16'h10 : 16'(160 >> i), 16'(n));
    end
    wr(8'h34, 8'h01);
    wr(8'h31, 8'h02);
    cnt(0, 4, n);
    chk("regen_period", 16'h20, 16'(n));
    wr(8'h33, 8'h02);
    wr(8'h36, 8'hf1);
    cnt(0, 4, n);
    chk("regen_wide", 16'h20, 16'(n));
    for (i = 0; i < 6; i++) wr(8'h36 - 8'(i), 8'h00);
    for (i = 1; i < 4; i++) begin
      wr(8'h30, {3'h4, 2'h3, 2'(i), 1'b1});
      repeat (100) @(negedge clk_sys);
      cnt(3, 4, n);
      chk("clean_period", 16'(16 >> (i - 1)), 16'(n));
      rc(8'h37, 8'h00, 8'hc0);
    end
    wr(8'h30, 8'h19);
    rc(8'h37, 8'h00, 8'hff);
    run = 1'b1;
    wr(8'h30, 8'h00);
    cnt(3, 4, n);
    chk("pin_clean_period", 16'h20, 16'(n));
    chk("oe", 16'h0, {15'h0, bclk_oe});
    summarize();
  end
  initial begin
    repeat (60000) @(posedge clk_sys);
    err_count++;
    summarize();
  end
endmodule : tb_top
`default_nettype wire
